// *** logic/acs_pkg.sv ***
// Constants, types and register map of the converter control sequencer
//
// Overview of operation
// - Control bit 13 set makes triggers edge-sensitive, clear makes them level-sensitive.
// - Bits 12:10 divide the converter clock by 1 to 32; reset code is 001.
// - Bits 9:8 set acquisition to 2, 4, 8 or 16 converter clocks; reset is 8.
// - Bit 7 gates new starts; clearing it leaves running continuous conversion going.
// - Bit 6 enables the conversion busy output pin.
// - Bit 5 powers the converter; wait 5 us after power-up before starting.
// - Bits 4:3 pick single-ended, fully differential or pseudo differential; 11 reserved.
// - Bits 2:0 pick the source: pin, timers, continuous software or logic array.
// - Source code 011 runs one software conversion, then hardware writes 000 back.
// - Each conversion end sets the ready flag and interrupt; result read clears flag.
// - Enabled busy pin is high during each conversion and low once it completes.
// - Result sits in bits 27:16; twos complement when fully differential, else straight binary.
package acs_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [31:0] CTRL_ADDR     = 32'hffff0500;
  localparam logic [31:0] STATUS_ADDR   = 32'hffff050c;
  localparam logic [31:0] RESULT_ADDR   = 32'hffff0510;
  localparam logic [31:0] IRQ_STAT_ADDR = 32'hffff0520;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffff0524;
  localparam logic [15:0] CTRL_RESET    = 16'h0600;
  localparam logic [15:0] CTRL_MASK     = 16'h3fff;

  // ***************************************************************
  // Control fields
  // ***************************************************************
  localparam int EDGE_BIT     = 13;
  localparam int DIV_MSB      = 12;
  localparam int DIV_LSB      = 10;
  localparam int ACQ_MSB      = 9;
  localparam int ACQ_LSB      = 8;
  localparam int START_EN_BIT = 7;
  localparam int BUSY_EN_BIT  = 6;
  localparam int POWER_BIT    = 5;
  localparam int MODE_MSB     = 4;
  localparam int MODE_LSB     = 3;
  localparam int SRC_MSB      = 2;
  localparam int SRC_LSB      = 0;
  localparam int RES_LSB      = 16;
  localparam int RES_MSB      = 27;

  localparam logic [2:0] SRC_PIN    = 3'h0;
  localparam logic [2:0] SRC_GENERAL_TIMER_ONE = 3'h1;
  localparam logic [2:0] SRC_GENERAL_TIMER_ZERO = 3'h2;
  localparam logic [2:0] SRC_SINGLE = 3'h3;
  localparam logic [2:0] SRC_CONT   = 3'h4;
  localparam logic [2:0] SRC_PLA    = 3'h5;
  localparam logic [2:0] DIV_MAX    = 3'h5;
  localparam logic [1:0] MODE_DIFF  = 2'h1;
  localparam logic [1:0] MODE_RSVD  = 2'h3;

  // ***************************************************************
  // Bus answers and timing
  // ***************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int POWERUP_NS     = 5000;
  localparam int CLK_PERIOD_NS  = 100;
  localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQUIRE, ST_CONVERT} acs_state_type;

endpackage

// *** logic/acs_axi_slave.sv ***
// AXI4-Lite slave front end for the converter registers
module acs_axi_slave (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             reg_wr,
  output logic [31:0]      reg_waddr,
  output logic [31:0]      reg_wdata,
  output logic [3:0]       reg_wstrb,
  input  wire logic        reg_whit,
  output logic             reg_rd,
  output logic [31:0]      reg_raddr,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rhit
);

  logic aw_held, w_held, next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [31:0] next_waddr, next_wdata, next_rdata;
  logic [3:0]  next_wstrb;
  logic [1:0]  next_bresp, next_rresp;

  assign awready   = !aw_held && !bvalid;
  assign wready    = !w_held && !bvalid;
  assign arready   = !rvalid;
  // Write waits until both halves are held, so either order works
  assign reg_wr    = aw_held && w_held && !bvalid;
  assign reg_rd    = arvalid && arready;
  assign reg_raddr = araddr;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_waddr   = reg_waddr;
    next_wdata   = reg_wdata;
    next_wstrb   = reg_wstrb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_waddr   = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_wdata  = wdata;
      next_wstrb  = wstrb;
    end
    if (reg_wr)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = reg_whit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
    if (reg_rd)
    begin
      next_rvalid = 1'b1;
      next_rdata  = reg_rdata;
      next_rresp  = reg_rhit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      reg_waddr <= 32'h0;
      reg_wdata <= 32'h0;
      reg_wstrb <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
      rvalid    <= 1'b0;
      rdata     <= 32'h0;
      rresp     <= 2'h0;
    end
    else
    begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      reg_waddr <= next_waddr;
      reg_wdata <= next_wdata;
      reg_wstrb <= next_wstrb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
    end
  end

endmodule // acs_axi_slave

// *** logic/acs_sequencer.sv ***
// Clock divider and acquisition/conversion phase sequencer
module acs_sequencer (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic [2:0] div_code,
  input  wire logic [1:0] acq_code,
  input  wire logic       core_done,
  output logic            busy,
  output logic            core_sample,
  output logic            core_convert,
  output logic            done
);

  acs_pkg::acs_state_type state, next_state;
  logic [4:0] div_cnt, next_div_cnt, div_limit;
  logic [3:0] acq_cnt, next_acq_cnt, acq_limit;
  logic [2:0] div_sel;
  logic       tick;
  logic [9:0] acq_cycles;

  // Codes above divide-by-32 are unspecified and clamp to it
  assign div_sel   = (div_code > acs_pkg::DIV_MAX) ? acs_pkg::DIV_MAX : div_code;
  assign div_limit = 5'((6'h1 << div_sel) - 6'h1);
  assign acq_limit = 4'((5'h2 << acq_code) - 5'h1);
  assign tick      = (div_cnt == div_limit);
  assign busy        = (state != acs_pkg::ST_IDLE);
  assign core_sample = (state == acs_pkg::ST_ACQUIRE);

  always_comb
  begin
    next_state   = state;
    next_div_cnt = div_cnt;
    next_acq_cnt = acq_cnt;
    core_convert = 1'b0;
    done         = 1'b0;
    case (state)
      acs_pkg::ST_IDLE:
        if (start)
        begin
          next_state   = acs_pkg::ST_ACQUIRE;
          next_div_cnt = 5'h0;
          next_acq_cnt = 4'h0;
        end
      acs_pkg::ST_ACQUIRE:
      begin
        next_div_cnt = tick ? 5'h0 : 5'(div_cnt + 5'h1);
        if (tick)
        begin
          if (acq_cnt == acq_limit)
          begin
            next_state   = acs_pkg::ST_CONVERT;
            core_convert = 1'b1;
          end
          else
            next_acq_cnt = 4'(acq_cnt + 4'h1);
        end
      end
      acs_pkg::ST_CONVERT:
        if (core_done)
        begin
          next_state = acs_pkg::ST_IDLE;
          done       = 1'b1;
        end
      default:
        next_state = acs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state   <= acs_pkg::ST_IDLE;
      div_cnt <= 5'h0;
      acq_cnt <= 4'h0;
    end
    else
    begin
      state   <= next_state;
      div_cnt <= next_div_cnt;
      acq_cnt <= next_acq_cnt;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !core_sample)
      acq_cycles <= 10'h0;
    else
      acq_cycles <= 10'(acq_cycles + 10'h1);
  end

  acq_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_convert |-> (acq_cycles + 10'h1)
      == (10'(acq_limit) + 10'h1) * (10'(div_limit) + 10'h1))
    else $error("acquisition length wrong");

endmodule // acs_sequencer

// *** logic/acs_top.sv ***
// Converter control sequencer top: registers, trigger selection, result and interrupt
module acs_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        external_start_pin,
  input  wire logic        general_timer_zero,
  input  wire logic        general_timer_one,
  input  wire logic        programmable_logic_array,
  output logic             conversion_busy_pin,
  output logic             conversion_busy_pin_oe,
  output logic             core_power_up,
  output logic [1:0]       core_input_mode,
  output logic             core_sample,
  output logic             core_convert,
  input  wire logic        core_done,
  input  wire logic [11:0] core_result,
  output logic             irq
);

  // ***************************************************************
  // Bus front end
  // ***************************************************************
  logic        reg_wr, reg_rd, reg_whit, reg_rhit;
  logic [31:0] reg_waddr, reg_wdata, reg_raddr, reg_rdata;
  logic [3:0]  reg_wstrb;

  acs_axi_slave u_axi (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .awaddr    (awaddr),
    .awvalid   (awvalid),
    .awready   (awready),
    .wdata     (wdata),
    .wstrb     (wstrb),
    .wvalid    (wvalid),
    .wready    (wready),
    .bresp     (bresp),
    .bvalid    (bvalid),
    .bready    (bready),
    .araddr    (araddr),
    .arvalid   (arvalid),
    .arready   (arready),
    .rdata     (rdata),
    .rresp     (rresp),
    .rvalid    (rvalid),
    .rready    (rready),
    .reg_wr    (reg_wr),
    .reg_waddr (reg_waddr),
    .reg_wdata (reg_wdata),
    .reg_wstrb (reg_wstrb),
    .reg_whit  (reg_whit),
    .reg_rd    (reg_rd),
    .reg_raddr (reg_raddr),
    .reg_rdata (reg_rdata),
    .reg_rhit  (reg_rhit)
  );

  // ***************************************************************
  // State
  // ***************************************************************
  logic [15:0] ctrl, next_ctrl, wr_mask;
  logic [31:0] result_word, next_result_word;
  logic        result_ready_flag, next_result_ready;
  logic        irq_status, next_irq_status;
  logic        irq_mask, next_irq_mask;
  logic        cont_run, next_cont_run;
  logic [5:0]  pwr_cnt, next_pwr_cnt;
  logic [3:0]  trig_prev;
  logic [3:0]  trig_now;
  logic        pwr_ready, rsvd, trig_sel, trig_sel_prev, trig_hit, start;
  logic        seq_busy, seq_done;
  logic [2:0]  src;
  logic        wr_ctrl, rd_result;

  assign src       = ctrl[acs_pkg::SRC_MSB:acs_pkg::SRC_LSB];
  assign wr_ctrl   = reg_wr && (reg_waddr == acs_pkg::CTRL_ADDR);
  assign rd_result = reg_rd && (reg_raddr == acs_pkg::RESULT_ADDR);
  assign wr_mask   = {{8{reg_wstrb[1]}}, {8{reg_wstrb[0]}}} & acs_pkg::CTRL_MASK;
  assign pwr_ready = ctrl[acs_pkg::POWER_BIT] && (pwr_cnt == 6'(acs_pkg::POWERUP_CYCLES));

  // ***************************************************************
  // Trigger selection
  // ***************************************************************
  assign trig_now = {programmable_logic_array, general_timer_zero, general_timer_one,
                     external_start_pin};

  // Reserved source codes never select a trigger
  assign rsvd = (ctrl[acs_pkg::MODE_MSB:acs_pkg::MODE_LSB] == acs_pkg::MODE_RSVD)
             || (src > acs_pkg::SRC_PLA);

  always_comb
  begin
    trig_sel      = 1'b0;
    trig_sel_prev = 1'b0;
    case (src)
      acs_pkg::SRC_PIN:
      begin
        trig_sel      = trig_now[0];
        trig_sel_prev = trig_prev[0];
      end
      acs_pkg::SRC_GENERAL_TIMER_ONE:
      begin
        trig_sel      = trig_now[1];
        trig_sel_prev = trig_prev[1];
      end
      acs_pkg::SRC_GENERAL_TIMER_ZERO:
      begin
        trig_sel      = trig_now[2];
        trig_sel_prev = trig_prev[2];
      end
      acs_pkg::SRC_PLA:
      begin
        trig_sel      = trig_now[3];
        trig_sel_prev = trig_prev[3];
      end
      default:
      begin
        trig_sel      = 1'b0;
        trig_sel_prev = 1'b0;
      end
    endcase
  end

  // An edge that lands while busy is dropped; level triggers simply retry
  assign trig_hit = ctrl[acs_pkg::EDGE_BIT] ? (trig_sel && !trig_sel_prev) : trig_sel;

  always_comb
  begin
    start = 1'b0;
    if (!seq_busy && pwr_ready && !rsvd)
    begin
      if (cont_run)
        start = 1'b1;
      else if (ctrl[acs_pkg::START_EN_BIT])
        start = trig_hit || (src == acs_pkg::SRC_SINGLE) || (src == acs_pkg::SRC_CONT);
    end
  end

  acs_sequencer u_seq (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .start        (start),
    .div_code     (ctrl[acs_pkg::DIV_MSB:acs_pkg::DIV_LSB]),
    .acq_code     (ctrl[acs_pkg::ACQ_MSB:acs_pkg::ACQ_LSB]),
    .core_done    (core_done),
    .busy         (seq_busy),
    .core_sample  (core_sample),
    .core_convert (core_convert),
    .done         (seq_done)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    next_ctrl         = ctrl;
    next_result_word  = result_word;
    next_result_ready = result_ready_flag;
    next_irq_status   = irq_status;
    next_irq_mask     = irq_mask;
    next_cont_run     = cont_run;
    next_pwr_cnt      = pwr_cnt;
    // Hardware revert happens first so a same-cycle software write wins
    if (seq_done && (src == acs_pkg::SRC_SINGLE))
      next_ctrl[acs_pkg::SRC_MSB:acs_pkg::SRC_LSB] = acs_pkg::SRC_PIN;
    if (wr_ctrl)
      next_ctrl = (ctrl & ~wr_mask) | (reg_wdata[15:0] & wr_mask);
    if (!ctrl[acs_pkg::POWER_BIT])
      next_pwr_cnt = 6'h0;
    else if (!pwr_ready)
      next_pwr_cnt = 6'(pwr_cnt + 6'h1);
    // Continuous run survives a cleared start gate, ends on source change
    if (src != acs_pkg::SRC_CONT || !ctrl[acs_pkg::POWER_BIT])
      next_cont_run = 1'b0;
    else if (start)
      next_cont_run = 1'b1;
    if (reg_wr && reg_waddr == acs_pkg::IRQ_MASK_ADDR && reg_wstrb[0])
      next_irq_mask = reg_wdata[0];
    if (reg_wr && reg_waddr == acs_pkg::IRQ_STAT_ADDR && reg_wstrb[0] && reg_wdata[0])
      next_irq_status = 1'b0;
    if (rd_result)
      next_result_ready = 1'b0;
    if (seq_done)
    begin
      next_result_ready = 1'b1;
      next_irq_status   = 1'b1;
      if (ctrl[acs_pkg::MODE_MSB:acs_pkg::MODE_LSB] == acs_pkg::MODE_DIFF)
        next_result_word = {{4{core_result[11]}}, core_result, 16'h0};
      else
        next_result_word = {4'h0, core_result, 16'h0};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl              <= acs_pkg::CTRL_RESET;
      result_word       <= 32'h0;
      result_ready_flag <= 1'b0;
      irq_status        <= 1'b0;
      irq_mask          <= 1'b0;
      cont_run          <= 1'b0;
      pwr_cnt           <= 6'h0;
      trig_prev         <= 4'h0;
    end
    else
    begin
      ctrl              <= next_ctrl;
      result_word       <= next_result_word;
      result_ready_flag <= next_result_ready;
      irq_status        <= next_irq_status;
      irq_mask          <= next_irq_mask;
      cont_run          <= next_cont_run;
      pwr_cnt           <= next_pwr_cnt;
      trig_prev         <= trig_now;
    end
  end

  // ***************************************************************
  // Read mux and outputs
  // ***************************************************************
  always_comb
  begin
    reg_rhit  = 1'b1;
    reg_rdata = 32'h0;
    case (reg_raddr)
      acs_pkg::CTRL_ADDR:     reg_rdata = {16'h0, ctrl};
      acs_pkg::STATUS_ADDR:   reg_rdata = {31'h0, result_ready_flag};
      acs_pkg::RESULT_ADDR:   reg_rdata = result_word;
      acs_pkg::IRQ_STAT_ADDR: reg_rdata = {31'h0, irq_status};
      acs_pkg::IRQ_MASK_ADDR: reg_rdata = {31'h0, irq_mask};
      default:                reg_rhit  = 1'b0;
    endcase
  end

  assign reg_whit = (reg_waddr == acs_pkg::CTRL_ADDR) || (reg_waddr == acs_pkg::STATUS_ADDR)
                 || (reg_waddr == acs_pkg::RESULT_ADDR) || (reg_waddr == acs_pkg::IRQ_STAT_ADDR)
                 || (reg_waddr == acs_pkg::IRQ_MASK_ADDR);

  assign conversion_busy_pin    = seq_busy && ctrl[acs_pkg::BUSY_EN_BIT];
  assign conversion_busy_pin_oe = ctrl[acs_pkg::BUSY_EN_BIT];
  assign core_power_up          = ctrl[acs_pkg::POWER_BIT];
  assign core_input_mode        = ctrl[acs_pkg::MODE_MSB:acs_pkg::MODE_LSB];
  assign irq                    = irq_status && irq_mask;

  // ***************************************************************
  // Checks
  // ***************************************************************
  power_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> ctrl[acs_pkg::POWER_BIT] && pwr_cnt == 6'(acs_pkg::POWERUP_CYCLES))
    else $error("start before power-up delay");
  reserved_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> !rsvd) else $error("start with reserved code");
  start_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && !cont_run |-> ctrl[acs_pkg::START_EN_BIT]) else $error("start while gated");
  edge_trig_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && ctrl[acs_pkg::EDGE_BIT] && src == acs_pkg::SRC_PIN |-> $rose(external_start_pin))
    else $error("edge mode start without edge");
  busy_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl[acs_pkg::BUSY_EN_BIT] |-> !conversion_busy_pin) else $error("busy pin not disabled");
  busy_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done |=> !conversion_busy_pin) else $error("busy pin held after conversion");
  single_revert_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done && src == acs_pkg::SRC_SINGLE && !wr_ctrl |=> src == acs_pkg::SRC_PIN)
    else $error("single source not reverted");
  ready_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done |=> result_ready_flag && irq_status) else $error("ready flag not set");
  result_pos_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_done |=> result_word[27:16] == $past(core_result) && result_word[15:0] == 16'h0
      && result_word[31:28] == (($past(core_input_mode) == acs_pkg::MODE_DIFF)
      ? {4{result_word[27]}} : 4'h0)) else $error("result word misformatted");

endmodule // acs_top

// *** test/acs_core_model.sv ***
// Behavioural model of the analog converter core behind the sequencer
module acs_core_model (
  input  wire logic        aclk,
  input  wire logic        core_convert,
  input  wire logic [3:0]  lat,
  input  wire logic [11:0] value,
  output logic             core_done,
  output logic [11:0]      core_result
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial core_done = 1'b0;
  initial core_result = 12'h000;
  // Result is valid only with done; it toggles otherwise so that a stale value cannot pass
  always @(posedge aclk)
  begin
    core_done   <= cnt == 1;
    core_result <= (cnt == 1) ? value : ~core_result;
    cnt         <= (core_convert === 1'b1) ? lat + 1 : (cnt > 0 ? cnt - 1 : 0);
  end
endmodule // acs_core_model

// *** test/acs_top_tb.sv ***
// Self-checking bench for the converter control sequencer
module acs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CTL = acs_pkg::CTRL_ADDR;
  localparam logic [31:0] IST = acs_pkg::IRQ_STAT_ADDR;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
  logic        conversion_busy_pin, conversion_busy_pin_oe, core_sample, core_convert, core_done;
  logic        irq, core_power_up;
  logic [31:0] awaddr, wdata, araddr, rdata, rq;
  logic [1:0]  bresp, rresp, core_input_mode, rr;
  logic [3:0]  trig, lat;
  logic [11:0] core_result, val;
  int          err_count = 0, checked = 0, n_conv = 0, n_samp = 0, n;
  int          srcs[4] = '{0, 1, 2, 5};
  int          rsv[4] = '{32'hbb, 32'hbc, 32'ha6, 32'ha7};
  acs_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready(1'b1), .external_start_pin(trig[0]), .general_timer_one(trig[1]),
    .general_timer_zero(trig[2]), .programmable_logic_array(trig[3]), .conversion_busy_pin,
    .conversion_busy_pin_oe, .core_power_up, .core_input_mode, .core_sample, .core_convert,
    .core_done, .core_result, .irq);
  acs_core_model core (.aclk, .core_convert, .lat, .value(val), .core_done, .core_result);
  always #50 aclk = ~aclk;
  always @(posedge aclk)
    if (core_convert === 1'b1) n_conv <= n_conv + 1;
  // Acquisition cycles seen, to hold the phase length against the divider and length codes
  always @(posedge aclk)
    if (core_sample === 1'b1) n_samp <= n_samp + 1;
  // ********
  // Tasks
  // ********
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready is sampled at the falling edge; inputs only move after rising edges
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    ta = !w;
    tw = !w;
    tr = w;
    @(posedge aclk);
    awaddr  <= a;
    araddr  <= a;
    wdata   <= d;
    awvalid <= w;
    wvalid  <= w;
    arvalid <= !w;
    while (!(ta && tw && tr))
    begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      tr = tr | (arvalid & arready);
      @(posedge aclk);
      awvalid <= awvalid & !ta;
      wvalid  <= wvalid & !tw;
      arvalid <= arvalid & !tr;
    end
    do @(negedge aclk); while ((w ? bvalid : rvalid) !== 1'b1);
    rq = rdata;
    rr = w ? bresp : rresp;
    @(posedge aclk);
  endtask
  task automatic wait_sig(ref logic s, input logic v, input string what);
    int k;
    k = 0;
    do
    begin
      @(negedge aclk);
      k++;
    end
    while (s !== v && k < 300);
    chk(what, s, v);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial
  begin
    #(4000 * 100);
    err_count++;
    finish_test();
  end
  initial
  begin
    {aclk, aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, trig, val} = '0;
    lat = 4'hf;
    void'($urandom(2038));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(0, CTL, 0);
    chk("ctrl reset", rq, 32'h600);
    xfer(0, 32'hffff0540, 0);
    chk("unmapped resp", rr, acs_pkg::RESP_SLVERR);
    chk("unmapped data", rq, 32'h0);
    xfer(1, CTL, 32'h20);
    chk("write resp", rr, acs_pkg::RESP_OKAY);
    chk("power out", core_power_up, 1);
    repeat (60) @(posedge aclk);
    $display("done reset");
    for (int m = 0; m < 3; m++)
    begin
      val <= 12'($urandom);
      n = n_samp;
      xfer(1, CTL, 32'he3 | (m << 3) | (m << 8) | (m << 10));
      xfer(1, CTL, 32'h63 | (m << 3) | (m << 8) | (m << 10));
      wait_sig(conversion_busy_pin, 1'b1, "busy high");
      chk("mode out", core_input_mode, m);
      chk("busy oe", conversion_busy_pin_oe, 1);
      wait_sig(conversion_busy_pin, 1'b0, "busy low");
      chk("acq length", n_samp - n, (2 << m) * (1 << m));
      xfer(0, CTL, 0);
      chk("src back", rq, 32'h60 | (m << 3) | (m << 8) | (m << 10));
      xfer(0, acs_pkg::STATUS_ADDR, 0);
      chk("ready set", rq, 1);
      xfer(0, acs_pkg::RESULT_ADDR, 0);
      chk("result", rq, {(m == 1) ? {4{val[11]}} : 4'h0, val, 16'h0});
      xfer(0, acs_pkg::STATUS_ADDR, 0);
      chk("ready clear", rq, 0);
    end
    wait_sig(irq, 1'b0, "irq masked");
    xfer(0, IST, 0);
    chk("irq status", rq, 1);
    xfer(1, acs_pkg::IRQ_MASK_ADDR, 1);
    wait_sig(irq, 1'b1, "irq raised");
    xfer(1, IST, 1);
    wait_sig(irq, 1'b0, "irq cleared");
    $display("done single and irq");
    lat <= 4'h2;
    foreach (srcs[i])
    begin
      xfer(1, CTL, 32'h20a0 | srcs[i]);
      n = n_conv;
      trig <= 4'hf ^ (4'h1 << i);
      repeat (40) @(negedge aclk);
      chk("unselected", n_conv - n, 0);
      n = n_conv;
      @(posedge aclk);
      trig <= 4'hf;
      repeat (40) @(negedge aclk);
      chk("edge start", n_conv - n, 1);
      xfer(1, CTL, 32'h00a0 | srcs[i]);
      n = n_conv;
      repeat (40) @(negedge aclk);
      chk("level start", n_conv - n > 4, 1);
      chk("busy off", {conversion_busy_pin_oe, conversion_busy_pin}, 0);
      xfer(1, CTL, 32'h0020 | srcs[i]);
      repeat (20) @(negedge aclk);
      n = n_conv;
      repeat (30) @(negedge aclk);
      chk("gated", n_conv - n, 0);
      @(posedge aclk);
      trig <= 4'h0;
    end
    foreach (rsv[i])
    begin
      n = n_conv;
      xfer(1, CTL, rsv[i]);
      repeat (30) @(negedge aclk);
      chk("reserved", n_conv - n, 0);
    end
    xfer(1, CTL, 32'ha4);
    repeat (20) @(negedge aclk);
    xfer(1, CTL, 32'h24);
    n = n_conv;
    repeat (40) @(negedge aclk);
    chk("cont runs", n_conv - n > 2, 1);
    $display("done triggers and continuous");
    finish_test();
  end
endmodule // acs_top_tb
